//--- verilog/dpr_defs.svh
/*
  Register offsets, field positions and reset values of the dual-port RAM block.
  Assumes inclusion by bare name from the design files under verilog/.
*/
`ifndef DPR_DEFS_SVH
`define DPR_DEFS_SVH

`define DPR_CTRL_OFFSET    12'h000
`define DPR_STAT_OFFSET    12'h004

`define DPR_CTRL_MODE_BIT  0
`define DPR_CTRL_WPOL_BIT  1
`define DPR_CTRL_RPOL_BIT  2
`define DPR_CTRL_RESET     3'h0

`define DPR_STAT_WCNT_LSB  0
`define DPR_STAT_RCNT_LSB  8
`define DPR_STAT_MODE_BIT  16

`define DPR_BYTE_ROWS      32
`define DPR_INDEX_W        6
`define DPR_WORD_W         8

`endif

//--- verilog/dpr_pkg.sv
/*
  Types and the clock-edge helper of the dual-port RAM block.
  Assumes the defines header is compiled with it.
*/
`default_nettype none
`include "dpr_defs.svh"

package dpr_pkg;

  typedef logic [`DPR_INDEX_W-1:0] dpr_index_t;
  typedef logic [`DPR_WORD_W-1:0]  dpr_word_t;

  typedef enum logic {
    DPR_MODE_BYTE   = 1'b0,
    DPR_MODE_NIBBLE = 1'b1
  } dpr_mode_e;

  // Edge of a sampled port clock, polarity chosen by software
  function automatic logic active_edge(input logic prev, input logic cur, input logic falling);
    active_edge = falling ? (prev & ~cur) : (~prev & cur);
  endfunction : active_edge

endpackage : dpr_pkg

`default_nettype wire

//--- verilog/dpr_port_if.sv
/*
  Carrier between the port control logic and the memory array.
  Assumes both ends sit in the same clock domain.
*/
`default_nettype none

interface dpr_port_if;
  dpr_pkg::dpr_mode_e  mode;
  logic                wr_fire;
  dpr_pkg::dpr_index_t wr_idx;
  dpr_pkg::dpr_word_t  wr_data;
  logic                rd_fire;
  logic                rd_hold;
  dpr_pkg::dpr_index_t rd_idx;
  dpr_pkg::dpr_word_t  rd_lookup;
  dpr_pkg::dpr_word_t  rd_word;

  modport ctl (
    output mode, wr_fire, wr_idx, wr_data, rd_fire, rd_hold, rd_idx,
    input  rd_lookup, rd_word
  );
  modport mem (
    input  mode, wr_fire, wr_idx, wr_data, rd_fire, rd_hold, rd_idx,
    output rd_lookup, rd_word
  );
endinterface : dpr_port_if

`default_nettype wire

//--- verilog/dpr_mem_array.sv
/*
  The 256-bit storage array with nibble merge and the registered read output.
  Assumes strobes already qualified by clock edges and enables.
*/
`default_nettype none
`include "dpr_defs.svh"

module dpr_mem_array #(
  parameter int ROWS = `DPR_BYTE_ROWS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Port strobes and data
  dpr_port_if.mem  port
);

  if (ROWS != `DPR_BYTE_ROWS) begin : g_bad_rows
    $error("dpr_mem_array: row count must match the six-bit index");
  end

  // Storage has no reset, as in the array it models
  logic [`DPR_WORD_W-1:0] mem_reg [ROWS];
  logic [`DPR_WORD_W-1:0] rd_word_reg;

  wire             nibble   = (port.mode == dpr_pkg::DPR_MODE_NIBBLE);
  wire [4:0]       wr_row   = port.wr_idx[4:0];
  wire             wr_hi    = port.wr_idx[5];
  wire [4:0]       rd_row   = port.rd_idx[4:0];
  wire             rd_hi    = port.rd_idx[5];
  wire [7:0]       wr_old   = mem_reg[wr_row];
  wire [7:0]       rd_row_w = mem_reg[rd_row];
  wire [7:0]       wr_merge = !nibble ? port.wr_data :
                              (wr_hi ? {port.wr_data[3:0], wr_old[3:0]}
                                     : {wr_old[7:4], port.wr_data[3:0]});
  wire [3:0]       rd_nib   = rd_hi ? rd_row_w[7:4] : rd_row_w[3:0];

  assign port.rd_lookup = nibble ? {4'h0, rd_nib} : rd_row_w;
  assign port.rd_word   = rd_word_reg;

  always_ff @(posedge clock) begin
    if (port.wr_fire) begin
      mem_reg[wr_row] <= wr_merge;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rd_word_reg <= 8'h00;
    end else if (port.rd_fire && port.rd_hold) begin
      rd_word_reg <= port.rd_lookup;
    end
  end

  AST_WRITE_STORE: assert property (@(posedge clock) disable iff (srst)
    port.wr_fire && !nibble |=> mem_reg[$past(wr_row)] == $past(port.wr_data))
    else $error("written byte not stored");

  AST_NIBBLE_OTHER_KEPT: assert property (@(posedge clock) disable iff (srst)
    port.wr_fire && nibble |=>
      (($past(wr_hi) ? mem_reg[$past(wr_row)][3:0] : mem_reg[$past(wr_row)][7:4])
        == ($past(wr_hi) ? $past(wr_old[3:0]) : $past(wr_old[7:4]))))
    else $error("nibble write disturbed the other nibble");

  AST_READ_LOAD: assert property (@(posedge clock) disable iff (srst)
    port.rd_fire && port.rd_hold |=> port.rd_word == $past(port.rd_lookup))
    else $error("read output not loaded with addressed word");

  AST_READ_HOLD: assert property (@(posedge clock) disable iff (srst)
    !(port.rd_fire && port.rd_hold) |=> $stable(port.rd_word))
    else $error("read output changed without a qualified read");

  AST_NIBBLE_READ_WIDTH: assert property (@(posedge clock) disable iff (srst)
    port.rd_fire && port.rd_hold && nibble |=> port.rd_word[7:4] == 4'h0)
    else $error("nibble read drove upper data bits");

endmodule : dpr_mem_array

`default_nettype wire

//--- verilog/dpr_ram_block.sv
/*
  Dual-port 256-bit RAM block: write port, read port, APB control and status.
  Assumes port pins synchronous to clock; port clocks are sampled, not used as clocks.
*/
// Chosen here: register access over APB and the address map.
`default_nettype none
`include "dpr_defs.svh"

// Overview of operation
// - Holds 256 bits, set up as 32 bytes or 64 nibbles.
// - Write and read ports act independently and may act in one cycle.
// - Each port takes a six-bit index covering 64 nibble locations.
// - In byte mode the top index bit is ignored on both ports.
// - Each port has its own clock; each edge polarity is selectable.
// - Eight-bit write data in, eight-bit read data out.
// - Write port: index, block select, enable, clock, data; read port: index, output hold, enable, clock, data, no block select.
module dpr_ram_block #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic                      clock,
  input  wire logic                      srst,
  // APB slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ADDR_W-1:0]         paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  // Write port
  input  wire logic [`DPR_INDEX_W-1:0]   write_index,
  input  wire logic                      block_select,
  input  wire logic                      write_enable,
  input  wire logic                      write_clk,
  input  wire logic [`DPR_WORD_W-1:0]    write_word,
  // Read port
  input  wire logic [`DPR_INDEX_W-1:0]   read_index,
  input  wire logic                      read_output_hold,
  input  wire logic                      read_enable,
  input  wire logic                      read_clk,
  output var  logic [`DPR_WORD_W-1:0]    read_word
);

  if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
    $error("dpr_ram_block: ADDR_W must lie between 3 and 32");
  end

  logic [2:0]  ctrl_reg;
  logic [7:0]  wcnt_reg;
  logic [7:0]  rcnt_reg;
  logic [31:0] prdata_reg;
  logic        wclk_prev_reg;
  logic        rclk_prev_reg;
  logic        armed_reg;

  dpr_port_if port ();

  // APB decode; zero wait states, so pready is simply high
  wire         setup     = psel && !penable;
  wire         access    = psel && penable;
  wire         hit_ctrl  = (paddr == ADDR_W'(`DPR_CTRL_OFFSET));
  wire         hit_stat  = (paddr == ADDR_W'(`DPR_STAT_OFFSET));
  wire         mapped    = hit_ctrl || hit_stat;
  wire         ctrl_wr   = access && pwrite && hit_ctrl;
  wire [31:0]  ctrl_word = {29'h0000_0000, ctrl_reg};
  wire [31:0]  stat_word = {15'h0000, ctrl_reg[`DPR_CTRL_MODE_BIT], rcnt_reg, wcnt_reg};
  wire [31:0]  rd_mux    = hit_ctrl ? ctrl_word : (hit_stat ? stat_word : 32'h0000_0000);

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata  = prdata_reg;

  // Port clock edges; first cycle after reset only samples, so a clock already
  // high at release is not mistaken for a rising edge
  wire wclk_fall = ctrl_reg[`DPR_CTRL_WPOL_BIT];
  wire rclk_fall = ctrl_reg[`DPR_CTRL_RPOL_BIT];
  wire wr_edge   = armed_reg &&
                   dpr_pkg::active_edge(wclk_prev_reg, write_clk, wclk_fall);
  wire rd_edge   = armed_reg &&
                   dpr_pkg::active_edge(rclk_prev_reg, read_clk, rclk_fall);
  wire nibble    = ctrl_reg[`DPR_CTRL_MODE_BIT];

  // Byte mode forces the top index bit low, so both halves of an index alias one row
  assign port.mode    = nibble ? dpr_pkg::DPR_MODE_NIBBLE : dpr_pkg::DPR_MODE_BYTE;
  assign port.wr_fire = wr_edge && write_enable && block_select;
  assign port.wr_idx  = nibble ? write_index : {1'b0, write_index[4:0]};
  assign port.wr_data = write_word;
  assign port.rd_fire = rd_edge && read_enable;
  assign port.rd_hold = read_output_hold;
  assign port.rd_idx  = nibble ? read_index : {1'b0, read_index[4:0]};
  assign read_word    = port.rd_word;

  // Polarity applies at once; change it only while both port clocks are idle
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl_reg <= `DPR_CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= pwdata[2:0];
    end
  end

  // Loaded in the setup cycle so the access needs no wait; status may lag one cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup) begin
      prdata_reg <= rd_mux;
    end
  end

  // Sampled port clocks; each level must stand for at least one clock
  always_ff @(posedge clock) begin
    if (srst) begin
      wclk_prev_reg <= 1'b0;
      rclk_prev_reg <= 1'b0;
      armed_reg     <= 1'b0;
    end else begin
      wclk_prev_reg <= write_clk;
      rclk_prev_reg <= read_clk;
      armed_reg     <= 1'b1;
    end
  end

  // Counts wrap silently; software compares differences, so no saturation
  always_ff @(posedge clock) begin
    if (srst) begin
      wcnt_reg <= 8'h00;
      rcnt_reg <= 8'h00;
    end else begin
      wcnt_reg <= wcnt_reg + 8'(port.wr_fire);
      rcnt_reg <= rcnt_reg + 8'(port.rd_fire);
    end
  end

  // One array serves both ports; a read and a write of one row return the old word
  dpr_mem_array #(
    .ROWS (`DPR_BYTE_ROWS)
  ) u_array (
    .clock (clock),
    .srst  (srst),
    .port  (port.mem)
  );

  AST_WCLK_EDGE: assert property (@(posedge clock) disable iff (srst)
    port.wr_fire |-> (write_clk != $past(write_clk)) && (write_clk == !wclk_fall))
    else $error("write strobe without the selected write clock edge");

  AST_RCLK_EDGE: assert property (@(posedge clock) disable iff (srst)
    armed_reg && read_enable && read_clk == !rclk_fall && $past(read_clk) == rclk_fall
      |-> port.rd_fire)
    else $error("selected read clock edge with read enable was missed");

  AST_BLOCK_SELECT: assert property (@(posedge clock) disable iff (srst)
    !block_select || !write_enable |-> !port.wr_fire)
    else $error("write strobe while block or write enable low");

  AST_BYTE_MSB_IGNORED: assert property (@(posedge clock) disable iff (srst)
    !nibble |-> !port.wr_idx[5] && !port.rd_idx[5] && port.rd_idx[4:0] == read_index[4:0])
    else $error("top index bit used in byte mode");

  AST_CONCURRENT: assert property (@(posedge clock) disable iff (srst)
    port.wr_fire && port.rd_fire && read_output_hold && !nibble &&
      write_index[4:0] != read_index[4:0]
      |=> read_word == $past(port.rd_lookup) ##1 $stable(read_word) || $past(port.rd_fire))
    else $error("concurrent write disturbed the read");

  AST_MODE_CTRL: assert property (@(posedge clock) disable iff (srst)
    ctrl_wr |=> (port.mode == dpr_pkg::DPR_MODE_NIBBLE) == $past(pwdata[0]) &&
      wclk_fall == $past(pwdata[1]) && rclk_fall == $past(pwdata[2]))
    else $error("mode or clock polarity did not follow the control write");

  // Port strobe and index, counter and bus-side checks
  AST_NO_EARLY_EDGE: assert property (@(posedge clock) disable iff (srst)
    !armed_reg |-> !port.wr_fire && !port.rd_fire)
    else $error("port strobe in the first cycle after reset");

  AST_READ_ENABLE: assert property (@(posedge clock) disable iff (srst)
    !read_enable |-> !port.rd_fire)
    else $error("read strobe while read enable low");

  AST_NIBBLE_INDEX_KEPT: assert property (@(posedge clock) disable iff (srst)
    nibble |-> port.wr_idx == write_index && port.rd_idx == read_index)
    else $error("six-bit index altered in nibble mode");

  AST_WCNT_STEP: assert property (@(posedge clock) disable iff (srst)
    port.wr_fire |=> wcnt_reg == $past(wcnt_reg) + 8'h01)
    else $error("write count did not advance on a stored write");

  AST_RCNT_STEP: assert property (@(posedge clock) disable iff (srst)
    port.rd_fire |=> rcnt_reg == $past(rcnt_reg) + 8'h01)
    else $error("read count did not advance on a read strobe");

  AST_PRDATA_HELD: assert property (@(posedge clock) disable iff (srst)
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");

  AST_UNMAPPED_ERR: assert property (@(posedge clock) disable iff (srst)
    psel && penable |-> pslverr == (paddr != ADDR_W'(`DPR_CTRL_OFFSET) &&
      paddr != ADDR_W'(`DPR_STAT_OFFSET)))
    else $error("error response does not match the address map");

  AST_CTRL_ONLY_WRITE: assert property (@(posedge clock) disable iff (srst)
    psel && penable && pwrite && paddr != ADDR_W'(`DPR_CTRL_OFFSET) |=> $stable(ctrl_reg))
    else $error("control changed by a write to another address");

  // Main scenarios
  COV_NIBBLE_WRITE: cover property (@(posedge clock) disable iff (srst)
    port.wr_fire && nibble && write_index[5]);
  COV_CONCURRENT: cover property (@(posedge clock) disable iff (srst)
    port.wr_fire && port.rd_fire);
  COV_FALLING_READ: cover property (@(posedge clock) disable iff (srst)
    port.rd_fire && rclk_fall && read_output_hold);
  COV_UNMAPPED: cover property (@(posedge clock) disable iff (srst) pslverr);
  COV_FALLING_WRITE: cover property (@(posedge clock) disable iff (srst)
    port.wr_fire && wclk_fall);

endmodule : dpr_ram_block

`default_nettype wire

//--- testbench/dpr_user_model.sv
/*
  Far-side user logic model: makes the write and read port clocks.
  Assumes toggle requests from the bench, one clock wide, spaced by two clocks or more.
*/
`default_nettype none

module dpr_user_model (
  // Clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // Toggle requests
  input  wire logic wtog,
  input  wire logic rtog,
  // Port clocks
  output var  logic write_clk,
  output var  logic read_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Port clocks stand still between requests, so only commanded edges occur
  always_ff @(posedge clock) begin
    if (srst) begin
      write_clk <= 1'b0;
      read_clk  <= 1'b0;
    end else begin
      if (wtog) write_clk <= ~write_clk;
      if (rtog) read_clk <= ~read_clk;
    end
  end
endmodule : dpr_user_model

`default_nettype wire

//--- testbench/dpr_ram_block_tb.sv
/*
  Self-checking bench: APB register access and both memory ports.
  Assumes the model makes the port clocks and the bench drives all other port pins.
*/
`default_nettype none

module dpr_ram_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, srst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [5:0]  write_index, read_index;
  logic [7:0]  write_word, read_word;
  logic        block_select, write_enable, read_output_hold, read_enable;
  logic        write_clk, read_clk, wtog, rtog, wfall, rfall;
  int          errors, n_compared, nw, nr;

  dpr_ram_block i_dpr_ram_block (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_index(write_index), .block_select(block_select),
    .write_enable(write_enable), .write_clk(write_clk), .write_word(write_word),
    .read_index(read_index), .read_output_hold(read_output_hold), .read_enable(read_enable),
    .read_clk(read_clk), .read_word(read_word));
  dpr_user_model i_dpr_user_model (.clock(clock), .srst(srst), .wtog(wtog), .rtog(rtog),
    .write_clk(write_clk), .read_clk(read_clk));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic end_of_test();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Four clocks per toggle call keeps each port clock level stable for the sampler
  task automatic tgl(input logic w, input logic r);
    @(posedge clock);
    wtog <= w;
    rtog <= r;
    @(posedge clock);
    wtog <= 1'b0;
    rtog <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : tgl

  task automatic xfer(input logic [5:0] wi, input logic [7:0] wd, input logic we,
                      input logic bs, input logic [5:0] ri, input logic h, input logic re);
    tgl(write_clk !== wfall, read_clk !== rfall);
    write_index      <= wi;
    write_word       <= wd;
    write_enable     <= we;
    block_select     <= bs;
    read_index       <= ri;
    read_output_hold <= h;
    read_enable      <= re;
    tgl(1'b1, 1'b1);
    write_enable <= 1'b0;
    block_select <= 1'b0;
    read_enable  <= 1'b0;
    nw += int'(we & bs);
    nr += int'(re);
  endtask : xfer

  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    end_of_test();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, wtog, rtog, wfall, rfall} = '0;
    {write_index, read_index, write_word, block_select, write_enable} = '0;
    {read_output_hold, read_enable, nw, nr, errors, n_compared} = '0;
    srst = 1'b1;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("ctrl", 32'h0000_0000, q);
    chk("read_word", 32'h0000_0000, {24'h00_0000, read_word});
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {q[30:0], e});
    xfer(6'h05, 8'hA5, 1, 1, 6'h00, 1, 0);
    xfer(6'h25, 8'h3C, 1, 1, 6'h00, 1, 0);
    xfer(6'h00, 8'h00, 0, 0, 6'h05, 1, 1);
    chk("byte alias", 32'h0000_003C, {24'h00_0000, read_word});
    xfer(6'h05, 8'hFF, 1, 0, 6'h25, 1, 1);
    xfer(6'h05, 8'hEE, 0, 1, 6'h05, 1, 1);
    chk("enables", 32'h0000_003C, {24'h00_0000, read_word});
    xfer(6'h09, 8'h5A, 1, 1, 6'h05, 1, 1);
    chk("concurrent", 32'h0000_003C, {24'h00_0000, read_word});
    xfer(6'h00, 8'h00, 0, 0, 6'h09, 1, 1);
    chk("second row", 32'h0000_005A, {24'h00_0000, read_word});
    xfer(6'h00, 8'h00, 0, 0, 6'h05, 0, 1);
    chk("output hold", 32'h0000_005A, {24'h00_0000, read_word});
    xfer(6'h03, 8'h11, 1, 1, 6'h00, 1, 0);
    @(posedge clock);
    write_word   <= 8'h22;
    write_enable <= 1'b1;
    block_select <= 1'b1;
    tgl(1'b1, 1'b0);
    write_enable <= 1'b0;
    block_select <= 1'b0;
    xfer(6'h00, 8'h00, 0, 0, 6'h03, 1, 1);
    chk("inactive edge", 32'h0000_0011, {24'h00_0000, read_word});
    // Fill row 2 as a byte so later nibble merges never see unwritten bits
    xfer(6'h22, 8'hC3, 1, 1, 6'h00, 1, 0);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("status", {16'h0000, nr[7:0], nw[7:0]}, q);
    apb(1'b1, 12'h000, 32'h0000_0007);
    wfall = 1'b1;
    rfall = 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("ctrl set", 32'h0000_0007, q);
    xfer(6'h02, 8'h07, 1, 1, 6'h00, 1, 0);
    xfer(6'h22, 8'hF9, 1, 1, 6'h00, 1, 0);
    xfer(6'h00, 8'h00, 0, 0, 6'h02, 1, 1);
    chk("nibble low", 32'h0000_0007, {24'h00_0000, read_word});
    xfer(6'h00, 8'h00, 0, 0, 6'h22, 1, 1);
    chk("nibble high", 32'h0000_0009, {24'h00_0000, read_word});
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk("status mode", {15'h0000, 1'b1, nr[7:0], nw[7:0]}, q);
    // Mid-run reset: output and control clear, memory contents stay
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst  <= 1'b0;
    wfall = 1'b0;
    rfall = 1'b0;
    chk("reset read_word", 32'h0000_0000, {24'h00_0000, read_word});
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk("reset ctrl", 32'h0000_0000, q);
    xfer(6'h00, 8'h00, 0, 0, 6'h05, 1, 1);
    chk("memory kept", 32'h0000_003C, {24'h00_0000, read_word});
    end_of_test();
  end
endmodule : dpr_ram_block_tb

`default_nettype wire
